// [dv/mthc_chk.sv]
// Checker of the loop, self-test and command rules at the top ports.
`timescale 1ns/100ps
`default_nettype none
module mthc_chk
  import mthc_pkg::*;
#(
  parameter int CLKS_PER_MS = MS_CLKS
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Leads and strobes into the block.
  input wire logic rts_i,
  input wire logic loop_test_request_i,
  input wire logic self_test_req_i,
  input wire logic cmd_valid_i,
  // Outputs of the block.
  input wire logic ready_for_sending_o,
  input wire logic test_indicator_o,
  input wire logic busy_o,
  input wire logic suspend_o,
  input wire mthc_alarm_t alarm_o,
  input wire mthc_cmd_rsp_t cmd_rsp_o,
  input wire logic reject_msg_o
);
  // All checks run on the system clock outside reset.
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  property p_rfs_off; !rts_i |=> !ready_for_sending_o; endproperty
  a_rfs_off: assert property (p_rfs_off)
    else $error("Ready for sending not dropped.");
  property p_ti_off; !loop_test_request_i |=> !test_indicator_o; endproperty
  a_ti_off: assert property (p_ti_off)
    else $error("Test indicator not dropped.");
  property p_rfs_on; $rose(ready_for_sending_o) |-> $past(rts_i); endproperty
  a_rfs_on: assert property (p_rfs_on)
    else $error("Ready for sending rose without a request.");
  property p_busy_why; $rose(busy_o) |-> $past(self_test_req_i); endproperty
  a_busy_why: assert property (p_busy_why)
    else $error("Busy rose without a self-test request.");
  property p_busy_on;
    $rose(self_test_req_i) && !suspend_o && !busy_o |=> busy_o;
  endproperty
  a_busy_on: assert property (p_busy_on)
    else $error("Busy not raised after a self-test request.");
  property p_hold;
    suspend_o [*2] |-> !ready_for_sending_o && !test_indicator_o;
  endproperty
  a_hold: assert property (p_hold)
    else $error("Loop leads active during self-test.");
  property p_quiet; suspend_o [*4] |-> alarm_o == 2'h0; endproperty
  a_quiet: assert property (p_quiet)
    else $error("Alarm reported during self-test.");
  property p_reject;
    cmd_valid_i && loop_test_request_i |=>
      cmd_rsp_o.beep && reject_msg_o && !cmd_rsp_o.accepted;
  endproperty
  a_reject: assert property (p_reject)
    else $error("Command not rejected while loop request is on.");
endmodule
bind mthc_top mthc_chk #(.CLKS_PER_MS(CLKS_PER_MS)) u_chk (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .rts_i(rts_i),
  .loop_test_request_i(loop_test_request_i),
  .self_test_req_i(self_test_req_i), .cmd_valid_i(cmd_valid_i),
  .ready_for_sending_o(ready_for_sending_o),
  .test_indicator_o(test_indicator_o), .busy_o(busy_o),
  .suspend_o(suspend_o), .alarm_o(alarm_o), .cmd_rsp_o(cmd_rsp_o),
  .reject_msg_o(reject_msg_o)
);
`default_nettype wire

// [dv/mthc_eng_model.sv]
// Behavioural self-test engine that answers each start after a delay.
`timescale 1ns/100ps
`default_nettype none
module mthc_eng_model (
  // Clock and test control.
  input wire logic sys_clk_i,
  input wire logic start_i,
  input wire logic err_cfg_i,
  input wire logic sev_cfg_i,
  input wire logic [7:0] delay_i,
  // Results toward the block.
  output logic done_o,
  output logic err_o,
  output logic severe_o
);
  logic run_r = 1'b0, done_r = 1'b0, tgl_r = 1'b0;
  logic [7:0] cnt_r = 8'h0;
  // Counts down the test time and reports done for one cycle.
  always_ff @(posedge sys_clk_i) begin
    tgl_r <= !tgl_r;
    done_r <= run_r && cnt_r == 8'h0;
    run_r <= (start_i === 1'b1) || (run_r && cnt_r != 8'h0);
    cnt_r <= (start_i === 1'b1) ? delay_i : cnt_r - 8'h1;
  end
  // Results are valid only with done and toggle otherwise.
  assign done_o = done_r;
  assign err_o = done_r ? err_cfg_i : tgl_r;
  assign severe_o = done_r ? sev_cfg_i : !tgl_r;
endmodule
`default_nettype wire

// [dv/mthc_top_tb.sv]
// Self-checking testbench of the modem test handshake control block.
`timescale 1ns/100ps
`default_nettype none
module mthc_top_tb;
  import mthc_pkg::*;
  localparam int CPM = 4;
  logic clk = 1'b0, nrst = 1'b0, rts = 1'b0, ltr = 1'b0, str = 1'b0;
  logic ploss = 1'b0, hfail = 1'b0, tone = 1'b0, lstat = 1'b0;
  logic cvalid = 1'b0, exitk = 1'b0, ccitt = 1'b0, clkint = 1'b0;
  logic ecfg = 1'b0, esev = 1'b0;
  logic [7:0] edly = 8'h20;
  mthc_cmd_t cmd = 3'h0;
  logic ready_for_sending, ti, busy, fail, start, done, err, sev, susp, ttx, rej, lamp;
  logic fmsg;
  mthc_alarm_t alarm;
  mthc_cmd_rsp_t rsp;
  int comparisons = 0, miscompares = 0, npwr = 0, nfl = 0, nst = 0;
  int ln, n0;
  logic [31:0] r;

  // Design with a short millisecond tick.
  mthc_top #(.CLKS_PER_MS(CPM)) uut (
    .sys_clk_i(clk), .nrst_i(nrst), .rts_i(rts),
    .loop_test_request_i(ltr), .self_test_req_i(str),
    .ready_for_sending_o(ready_for_sending), .test_indicator_o(ti), .busy_o(busy),
    .failed_o(fail), .selftest_start_o(start), .selftest_done_i(done),
    .selftest_err_i(err), .selftest_severe_i(sev), .suspend_o(susp),
    .power_loss_i(ploss), .hard_fail_i(hfail), .tone_detect_i(tone),
    .local_status_i(lstat), .tone_tx_o(ttx), .alarm_o(alarm),
    .cmd_valid_i(cvalid), .cmd_i(cmd), .exit_key_i(exitk),
    .ccitt_mode_i(ccitt), .remote_clk_internal_i(clkint),
    .cmd_rsp_o(rsp), .reject_msg_o(rej), .lamp_all_o(lamp),
    .fail_msg_o(fmsg)
  );

  // Self-test engine behind the block.
  mthc_eng_model u_eng (
    .sys_clk_i(clk), .start_i(start), .err_cfg_i(ecfg), .sev_cfg_i(esev),
    .delay_i(edly), .done_o(done), .err_o(err), .severe_o(sev)
  );

  // Free-running system clock.
  always #20 clk = ~clk;

  // Counts alarm reports and engine starts.
  always @(posedge clk) begin
    if (alarm.pwr_off === 1'b1) npwr++;
    if (alarm.failure === 1'b1) nfl++;
    if (start === 1'b1) nst++;
  end

  // Compares one value and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits a bounded time for a level, then compares it.
  task automatic wt(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++) begin
      @(posedge clk);
      #1;
    end
    chk(s, v);
  endtask

  // Measures in cycles how long a signal stays high.
  task automatic len(ref logic s);
    ln = 0;
    while (s === 1'b1 && ln < 30000) begin
      @(posedge clk);
      #1;
      ln++;
    end
  endtask

  // True when a lies within t of b.
  function automatic logic near(input int a, input int b, input int t);
    return a >= b - t && a <= b + t;
  endfunction

  // Expected command outcome from the loop lead and options.
  function automatic mthc_cmd_rsp_t exp_rsp(input logic l, input mthc_cmd_t c,
                                            input logic cc, input logic ci);
    if (l) return mthc_cmd_rsp_t'(3'h1);
    if (c.remote && (cc || (c.speed_chg && !ci))) return mthc_cmd_rsp_t'(3'h2);
    return mthc_cmd_rsp_t'(3'h4);
  endfunction

  // Presents one command for a single cycle.
  task automatic issue(input mthc_cmd_t c);
    @(posedge clk);
    cmd <= c;
    cvalid <= 1'b1;
    @(posedge clk);
    cvalid <= 1'b0;
    #1;
  endtask

  // Sends a received tone of the given length in ms.
  task automatic tone_rx(input int ms);
    @(posedge clk);
    tone <= 1'b1;
    repeat (ms * CPM) @(posedge clk);
    tone <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
  endtask

  // Applies a power loss and measures the tone sent for it.
  task automatic tx(input int ms, input int e, input int t);
    @(posedge clk);
    ploss <= 1'b1;
    fork
      begin
        repeat (ms * CPM) @(posedge clk);
        ploss <= 1'b0;
      end
      begin
        wt(ttx, 1'b1, 4);
        len(ttx);
      end
    join
    chk(near(ln, e * CPM, t * CPM + 2), 1'b1);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    #(40 * 90000);
    miscompares++;
    test_done;
  end

  // Main test sequence.
  initial begin
    r = $urandom(39669);
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    wt(susp, 1'b0, 600);
    @(posedge clk);
    rts <= 1'b1;
    wt(ready_for_sending, 1'b1, 200 * CPM);
    @(posedge clk);
    rts <= 1'b0;
    wt(ready_for_sending, 1'b0, 50 * CPM);
    @(posedge clk);
    ltr <= 1'b1;
    wt(ti, 1'b1, 700 * CPM);
    @(posedge clk);
    rts <= 1'b1;
    wt(ready_for_sending, 1'b1, 200 * CPM);
    @(posedge clk);
    rts <= 1'b0;
    wt(ready_for_sending, 1'b0, 50 * CPM);
    @(posedge clk);
    ltr <= 1'b0;
    wt(ti, 1'b0, 100 * CPM);
    $display("loop handshake test done");
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      r = $urandom;
      ltr <= r[0];
      ccitt <= r[1];
      clkint <= r[2];
      issue(mthc_cmd_t'(r[5:3]));
      chk(rsp, exp_rsp(r[0], mthc_cmd_t'(r[5:3]), r[1], r[2]));
      if (r[0]) chk(rej, 1'b1);
      @(posedge clk);
      exitk <= 1'b1;
      @(posedge clk);
      exitk <= 1'b0;
      #1;
      chk(rej, 1'b0);
    end
    @(posedge clk);
    ltr <= 1'b0;
    wt(lamp, 1'b0, 5001 * CPM);
    issue(mthc_cmd_t'(3'h1));
    len(lamp);
    chk(near(ln, 5000 * CPM, CPM + 2), 1'b1);
    $display("command test done");
    for (int e = 0; e < 2; e++) begin
      @(posedge clk);
      ecfg <= e[0];
      edly <= 8'($urandom_range(250, 100));
      tone <= 1'b1;
      npwr = 0;
      nfl = 0;
      repeat (95 * CPM) @(posedge clk);
      chk({busy, fail}, 2'h0);
      str <= 1'b1;
      repeat (3) @(posedge clk);
      tone <= 1'b0;
      str <= 1'b0;
      #1;
      chk(busy, 1'b1);
      issue(mthc_cmd_t'(3'h1));
      chk(rsp, mthc_cmd_rsp_t'(3'h2));
      chk(lamp, 1'b0);
      wt(busy, 1'b0, 4000 * CPM);
      chk(fail, e[0]);
      repeat (8) @(posedge clk);
      chk(npwr + nfl, 0);
    end
    $display("self-test test done");
    for (int k = 0; k < 3; k++) begin
      npwr = 0;
      nfl = 0;
      tone_rx(100 + 100 * k);
      chk(npwr, k == 0);
      chk(nfl, k == 2);
    end
    @(posedge clk);
    lstat <= 1'b1;
    npwr = 0;
    nfl = 0;
    tone_rx(100);
    tone_rx(300);
    chk(npwr + nfl, 1);
    @(posedge clk);
    lstat <= 1'b0;
    tx(50, 50, 1);
    tx(200, 100, 20);
    @(posedge clk);
    hfail <= 1'b1;
    wt(ttx, 1'b1, 2 * CPM + 4);
    len(ttx);
    chk(near(ln, 300 * CPM, CPM + 2), 1'b1);
    @(posedge clk);
    hfail <= 1'b0;
    $display("tone test done");
    @(posedge clk);
    esev <= 1'b1;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    wt(fmsg, 1'b1, 600);
    n0 = nst;
    @(posedge clk);
    esev <= 1'b0;
    #1;
    len(fmsg);
    chk(near(ln, 2000 * CPM, CPM + 2), 1'b1);
    repeat (4) @(posedge clk);
    wt(susp, 1'b0, 600);
    chk(nst - n0, 1);
    $display("bring-up test done");
    test_done;
  end
endmodule
`default_nettype wire

// [shared/mthc_pkg.sv]
// Constants and types shared by the modem test handshake control block.
package mthc_pkg;

  // System clock and millisecond tick.
  localparam int CLK_FREQ_HZ = 25000000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CLKS = CLK_FREQ_HZ / MS_PER_S;

  // Width of every millisecond counter.
  localparam int MS_W = 17;

  // Loop handshake response times in ms.
  localparam logic [16:0] RFS_OFF_MAX_MS = 17'h00032;
  localparam logic [16:0] TI_ON_MAX_MS = 17'h002BC;
  localparam logic [16:0] RFS_ON_MAX_MS = 17'h000C8;
  localparam logic [16:0] TI_OFF_MAX_MS = 17'h00064;
  localparam logic [16:0] LOOP_SETUP_MS = 17'h00014;
  localparam logic [16:0] RFS_DELAY_MS = 17'h0000A;

  // Self-test timing in ms.
  localparam logic [16:0] BUSY_ON_MAX_MS = 17'h000C8;
  localparam logic [16:0] BUSY_OFF_MAX_MS = 17'h00FA0;
  localparam logic [16:0] SELFTEST_GUARD_MS = 17'h00DAC;
  localparam logic [16:0] FAIL_MSG_MS = 17'h007D0;

  // Transmitted tone timing in ms.
  localparam logic [16:0] PWR_TONE_MS = 17'h00064;
  localparam logic [16:0] FAIL_TONE_MS = 17'h0012C;
  localparam logic [16:0] FAIL_PERIOD_MS = 17'h15F90;

  // Received tone classification windows in ms.
  localparam logic [16:0] PWR_RX_MIN_MS = 17'h00050;
  localparam logic [16:0] PWR_RX_MAX_MS = 17'h00078;
  localparam logic [16:0] FAIL_RX_MIN_MS = 17'h000F0;
  localparam logic [16:0] FAIL_RX_MAX_MS = 17'h00168;

  // Keypad lamp test time in ms.
  localparam logic [16:0] LAMP_TEST_MS = 17'h01388;

  // Self-test sequencer states.
  typedef enum logic [1:0] {
    ST_POR,
    ST_RUN,
    ST_FAILMSG,
    ST_IDLE
  } mthc_st_state_t;

  // Operator or remote command presented by the keypad display.
  typedef struct packed {
    logic remote;
    logic speed_chg;
    logic lamp_test;
  } mthc_cmd_t;

  // Command outcome flags toward the keypad display.
  typedef struct packed {
    logic accepted;
    logic not_executed;
    logic beep;
  } mthc_cmd_rsp_t;

  // Received alarm tone reports.
  typedef struct packed {
    logic pwr_off;
    logic failure;
  } mthc_alarm_t;

endpackage

// [verilog/mthc_ms_timer.sv]
// Millisecond tick divider and restartable elapsed-millisecond counter.
`timescale 1ns/100ps
`default_nettype none
module mthc_ms_timer
  import mthc_pkg::*;
#(
  parameter int CLKS_PER_MS = MS_CLKS
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Control.
  input wire logic restart_i,
  // Timing outputs.
  output logic ms_tick_o,
  output logic [MS_W-1:0] ms_count_o
);

  logic [15:0] div_r;

  // Divider produces a one-cycle tick each millisecond.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i || restart_i) begin
      div_r <= 16'h0000;
      ms_tick_o <= 1'b0;
    end else if (div_r == 16'(CLKS_PER_MS - 1)) begin
      div_r <= 16'h0000;
      ms_tick_o <= 1'b1;
    end else begin
      div_r <= div_r + 16'h0001;
      ms_tick_o <= 1'b0;
    end
  end

  // Elapsed milliseconds since restart, saturating at full scale.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i || restart_i) begin
      ms_count_o <= '0;
    end else if (ms_tick_o && (ms_count_o != '1)) begin
      ms_count_o <= ms_count_o + 17'h00001;
    end
  end

endmodule
`default_nettype wire

// [verilog/mthc_top.sv]
// Test handshake control of a line modem facing a host test adapter.
//
// Function
// R1: Adapter sends loop data only after ready_for_sending.
// R2: Adapter may guard handshake with 2100 ms timer.
// R3: Request-to-send off drops ready_for_sending within 50 ms.
// R4: Loop test request raises test_indicator within 700 ms.
// R5: Request-to-send on raises ready_for_sending within 200 ms.
// R6: Loop end: drop ready 50 ms, indicator 100 ms.
// R7: Self-test preempts and suspends all other functions; the code keeps sending line tones during a self-test.
// R8: Failure bit set on any self-test error.
// R9: Busy bit raised only for host self-test request.
// R10: Adapter treats failed or long busy as error.
// R11: Busy rises within 200 ms of self-test request.
// R12: Busy clears within 4 s after request withdrawn.
// R13: Ignore received alarm tones during self-test.
// R14: Local status reports only one of two tones.
// R15: Power-off tone 100 ms, or shorter loss length.
// R16: Failure tone 300 ms, repeated every 90 s.
// R17: Classify received tones by their measured length.
// R18: Loop request active rejects operator commands with beep.
// R19: Standards mode refuses remote commands, not executed.
// R20: Remote speed change needs remote internal clock.
// R21: Lamp test lights every display position 5 s.
// R22: Severe bring-up error shows failure 2 s, repeats.
// R23: Shared millisecond timer restarted on lead transitions.
`timescale 1ns/100ps
`default_nettype none
module mthc_top
  import mthc_pkg::*;
#(
  parameter int CLKS_PER_MS = MS_CLKS
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Interface leads from the host test adapter.
  input wire logic rts_i,
  input wire logic loop_test_request_i,
  input wire logic self_test_req_i,
  // Interface leads toward the host test adapter.
  output logic ready_for_sending_o,
  output logic test_indicator_o,
  output logic busy_o,
  output logic failed_o,
  // Internal self-test engine.
  output logic selftest_start_o,
  input wire logic selftest_done_i,
  input wire logic selftest_err_i,
  input wire logic selftest_severe_i,
  output logic suspend_o,
  // Line tone sense and send.
  input wire logic power_loss_i,
  input wire logic hard_fail_i,
  input wire logic tone_detect_i,
  input wire logic local_status_i,
  output logic tone_tx_o,
  output mthc_alarm_t alarm_o,
  // Keypad display commands and status.
  input wire logic cmd_valid_i,
  input wire mthc_cmd_t cmd_i,
  input wire logic exit_key_i,
  input wire logic ccitt_mode_i,
  input wire logic remote_clk_internal_i,
  output mthc_cmd_rsp_t cmd_rsp_o,
  output logic reject_msg_o,
  output logic lamp_all_o,
  output logic fail_msg_o
);

  logic ms_tick;
  logic [MS_W-1:0] lead_ms;
  logic rts_d_r;
  logic tc_d_r;
  logic lead_edge;
  mthc_st_state_t st_state_r;
  logic [MS_W-1:0] st_ms_r;
  logic req_d_r;
  logic host_test_r;
  logic running;
  logic [MS_W-1:0] ptone_ms_r;
  logic [MS_W-1:0] ftone_ms_r;
  logic [MS_W-1:0] rx_ms_r;
  logic tone_d_r;
  logic alarm_lock_r;
  logic [MS_W-1:0] lamp_ms_r;

  // Lead transitions restart the shared millisecond timer.
  assign lead_edge = (rts_i != rts_d_r) ||
                     (loop_test_request_i != tc_d_r); // R23

  mthc_ms_timer #(
    .CLKS_PER_MS(CLKS_PER_MS)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .restart_i(lead_edge),
    .ms_tick_o(ms_tick),
    .ms_count_o(lead_ms)
  );

  // Previous lead levels for edge detection.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      rts_d_r <= 1'b0;
      tc_d_r <= 1'b0;
      req_d_r <= 1'b0;
      tone_d_r <= 1'b0;
    end else begin
      rts_d_r <= rts_i;
      tc_d_r <= loop_test_request_i;
      req_d_r <= self_test_req_i;
      tone_d_r <= tone_detect_i;
    end
  end

  // A self-test in progress holds the loop leads, received alarms, lamp test start and command execution still.
  assign running = (st_state_r != ST_IDLE); // R7

  // Ready-for-sending falls at once with request-to-send and rises after
  // the configured delay; the adapter waits for it before looping data.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      ready_for_sending_o <= 1'b0;
    end else if (running || !rts_i) begin
      ready_for_sending_o <= 1'b0; // R3 R6 R7
    end else if (lead_ms >= RFS_DELAY_MS) begin
      ready_for_sending_o <= 1'b1; // R5 R1
    end
  end

  // Test indicator follows the loop test request after the loop setup
  // time, and drops at once when the request is released.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      test_indicator_o <= 1'b0;
    end else if (running || !loop_test_request_i) begin
      test_indicator_o <= 1'b0; // R6
    end else if (lead_ms >= LOOP_SETUP_MS) begin
      test_indicator_o <= 1'b1; // R4
    end
  end

  // Self-test sequencer: bring-up test after reset, then host requests.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      st_state_r <= ST_POR;
      st_ms_r <= '0;
      host_test_r <= 1'b0;
      selftest_start_o <= 1'b0;
      fail_msg_o <= 1'b0;
    end else begin
      selftest_start_o <= 1'b0;
      case (st_state_r)
        ST_POR: begin
          st_state_r <= ST_RUN;
          st_ms_r <= '0;
          host_test_r <= 1'b0;
          selftest_start_o <= 1'b1;
        end
        ST_RUN: begin
          if (ms_tick && (st_ms_r != '1)) begin
            st_ms_r <= st_ms_r + 17'h00001;
          end
          if (selftest_done_i || (st_ms_r >= SELFTEST_GUARD_MS)) begin
            st_ms_r <= '0;
            if (!host_test_r && selftest_severe_i && selftest_done_i) begin
              st_state_r <= ST_FAILMSG; // R22
              fail_msg_o <= 1'b1;
            end else begin
              st_state_r <= ST_IDLE;
            end
          end
        end
        ST_FAILMSG: begin
          if (ms_tick) begin
            st_ms_r <= st_ms_r + 17'h00001;
          end
          if (st_ms_r >= FAIL_MSG_MS) begin
            fail_msg_o <= 1'b0;
            st_state_r <= ST_POR; // R22
          end
        end
        ST_IDLE: begin
          if (self_test_req_i && !req_d_r) begin
            st_state_r <= ST_RUN; // R7
            st_ms_r <= '0;
            host_test_r <= 1'b1;
            selftest_start_o <= 1'b1;
          end
        end
        default: begin
          st_state_r <= ST_POR;
        end
      endcase
    end
  end

  // Suspend flag toward the rest of the modem.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      suspend_o <= 1'b1;
    end else begin
      suspend_o <= running || (st_state_r == ST_POR); // R7
    end
  end

  // Busy rises on the next cycle of a host request and clears once the
  // test is over and the request has been withdrawn.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      busy_o <= 1'b0;
    end else if ((st_state_r == ST_IDLE) && self_test_req_i && !req_d_r) begin
      busy_o <= 1'b1; // R9 R11
    end else if ((st_state_r == ST_IDLE) && !self_test_req_i) begin
      busy_o <= 1'b0; // R12
    end
  end

  // Failure bit set by any test error or guard expiry, cleared only when
  // a fresh host test starts.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      failed_o <= 1'b0;
    end else if ((st_state_r == ST_RUN) &&
                 ((selftest_done_i && selftest_err_i) ||
                  (st_ms_r >= SELFTEST_GUARD_MS))) begin
      failed_o <= 1'b1; // R8
    end else if ((st_state_r == ST_IDLE) && self_test_req_i && !req_d_r) begin
      failed_o <= 1'b0;
    end
  end

  // Power-off tone lasts as long as the loss, capped at its full length.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i || !power_loss_i) begin
      ptone_ms_r <= '0;
    end else if (ms_tick && (ptone_ms_r < PWR_TONE_MS)) begin
      ptone_ms_r <= ptone_ms_r + 17'h00001; // R15
    end
  end

  // Failure tone period counter, free running while the fault stands.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i || !hard_fail_i) begin
      ftone_ms_r <= '0;
    end else if (ms_tick) begin
      if (ftone_ms_r >= FAIL_PERIOD_MS - 17'h00001) begin
        ftone_ms_r <= '0; // R16
      end else begin
        ftone_ms_r <= ftone_ms_r + 17'h00001;
      end
    end
  end

  // Tone output; the power-off tone wins over the failure tone.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      tone_tx_o <= 1'b0;
    end else if (power_loss_i) begin
      tone_tx_o <= (ptone_ms_r < PWR_TONE_MS); // R15
    end else begin
      tone_tx_o <= hard_fail_i && (ftone_ms_r < FAIL_TONE_MS); // R16
    end
  end

  // Received tone length in ms, measured while the tone stands.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i || !tone_detect_i) begin
      rx_ms_r <= '0;
    end else if (ms_tick && (rx_ms_r != '1)) begin
      rx_ms_r <= rx_ms_r + 17'h00001; // R17
    end
  end

  // Lock that lets only one alarm through per local status operation.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i || !local_status_i) begin
      alarm_lock_r <= 1'b0;
    end else if (alarm_o.pwr_off || alarm_o.failure) begin
      alarm_lock_r <= 1'b1; // R14
    end
  end

  // Classify each tone at its end; ignored during a self-test.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      alarm_o <= '0;
    end else begin
      alarm_o <= '0;
      if (tone_d_r && !tone_detect_i && !running && !alarm_lock_r) begin // R13 R14
        if ((rx_ms_r >= PWR_RX_MIN_MS) && (rx_ms_r <= PWR_RX_MAX_MS)) begin
          alarm_o.pwr_off <= 1'b1; // R17
        end else if ((rx_ms_r >= FAIL_RX_MIN_MS) &&
                     (rx_ms_r <= FAIL_RX_MAX_MS)) begin
          alarm_o.failure <= 1'b1; // R17
        end
      end
    end
  end

  // Command decode: one-cycle outcome pulses, no effect on data.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cmd_rsp_o <= '0;
    end else begin
      cmd_rsp_o <= '0;
      if (cmd_valid_i) begin
        if (loop_test_request_i) begin
          cmd_rsp_o.beep <= 1'b1; // R18
        end else if (running) begin
          cmd_rsp_o.not_executed <= 1'b1; // R7
        end else if (cmd_i.remote && ccitt_mode_i) begin
          cmd_rsp_o.not_executed <= 1'b1; // R19
        end else if (cmd_i.remote && cmd_i.speed_chg &&
                     !remote_clk_internal_i) begin
          cmd_rsp_o.not_executed <= 1'b1; // R20
        end else begin
          cmd_rsp_o.accepted <= 1'b1;
        end
      end
    end
  end

  // Busy-with-loop message held until the exit key is pressed.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      reject_msg_o <= 1'b0;
    end else if (cmd_valid_i && loop_test_request_i) begin
      reject_msg_o <= 1'b1; // R18
    end else if (exit_key_i) begin
      reject_msg_o <= 1'b0;
    end
  end

  // Lamp test counter runs while every position is lit.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      lamp_ms_r <= '0;
      lamp_all_o <= 1'b0;
    end else if (cmd_valid_i && cmd_i.lamp_test && !cmd_i.remote &&
                 !loop_test_request_i && !running) begin
      lamp_ms_r <= '0;
      lamp_all_o <= 1'b1; // R21
    end else if (lamp_all_o) begin
      if (lamp_ms_r >= LAMP_TEST_MS) begin
        lamp_all_o <= 1'b0; // R21
      end else if (ms_tick) begin
        lamp_ms_r <= lamp_ms_r + 17'h00001;
      end
    end
  end

endmodule
`default_nettype wire
